// ===== hdl/wkev_params.svh
// wkev_params.svh: offsets, field layouts, reset values and timing counts
// of the wake event block.
// assumes: included by bare name from the package and the top module.
`ifndef WKEV_PARAMS_SVH
`define WKEV_PARAMS_SVH

// ====================================================================
// register indices (byte address is four times the index)
`define WKEV_IDX_MASTER_EN 6'h01
`define WKEV_IDX_STS_SECOND 6'h03
`define WKEV_IDX_STS_THIRD 6'h04
`define WKEV_IDX_EN_FIRST 6'h05
`define WKEV_IDX_EN_SECOND 6'h06
`define WKEV_IDX_IRQ_STATUS 6'h20
`define WKEV_IDX_IRQ_MASK 6'h21

// ====================================================================
// reset values and implemented-bit masks
`define WKEV_RESET_VALUE 8'h00
`define WKEV_STS_SECOND_BITS 8'hbf
`define WKEV_STS_THIRD_BITS 8'hff
`define WKEV_EN_FIRST_BITS 8'hce
`define WKEV_EN_SECOND_BITS 8'hbf
`define WKEV_MASTER_EN_BITS 8'h01
`define WKEV_IRQ_BITS 8'h03

// ====================================================================
// field positions
`define WKEV_STS_SECOND_WATCHDOG 7
`define WKEV_IRQ_STATUS_SET 0
`define WKEV_IRQ_REQUEST_RISE 1

// ====================================================================
// pin event shaping
`define WKEV_PIN_COUNT 14
`define WKEV_ANY_EDGE_PINS 14'h3ffe
`define WKEV_PRIME_CYCLES 3'h4

`endif

// ===== hdl/wkev_pkg.sv
// wkev_pkg.sv: types of the wake event block.
// assumes: constants come from wkev_params.svh.
`include "wkev_params.svh"

package wkev_pkg;

  // ==================================================================
  // wake pins, one bit each, raw from the pads
  typedef struct packed {
    logic gpio_37;
    logic gpio_36;
    logic gpio_35;
    logic gpio_34;
    logic gpio_33;
    logic gpio_32;
    logic gpio_31;
    logic gpio_30_or_ring_indicate_three;
    logic gpio_23;
    logic gpio_22;
    logic gpio_21;
    logic gpio_20;
    logic ring_indicate_two_or_gpio_50;
    logic ring_indicate_one_n;
  } wkev_pins_type;

  // ==================================================================
  // whole state of the block
  typedef struct packed {
    logic [`WKEV_PIN_COUNT-1:0] sync_first;
    logic [`WKEV_PIN_COUNT-1:0] sync_second;
    logic [`WKEV_PIN_COUNT-1:0] sync_third;
    logic [`WKEV_PIN_COUNT-1:0] level;
    logic [2:0] prime;
    logic watchdog_level;
    logic [7:0] wake_status_second;
    logic [7:0] wake_status_third;
    logic [7:0] wake_enable_first;
    logic [7:0] wake_enable_second;
    logic wake_master_enable;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic wake_request;
    logic [7:0] read_byte;
    logic slave_error;
  } wkev_state_type;

endpackage

// ===== hdl/wkev_top.sv
// wkev_top.sv: wake event status and enable logic behind an APB slave.
// assumes: presetn is the standby power-on reset; main-supply, soft and
// hard resets never reach this block; watchdog_wake is on pclk.
//
// How it works
// - any source event sets its status bit
// - writing one clears a status bit
// - writing zero leaves status bit unchanged
// - pin event counts whatever alternate function
// - status survives main, soft, hard resets
// - enables survive main, soft, hard resets
// - standby power-on reset clears all four
// - second status, second enable and master assert wake request
// - disabled source records but never requests
// - second status/enable bit to source map
// - third status maps pins thirty to 37
// - first enable maps gpio 11-13, 16, 17
// - second enable one bit per source
// - master enable bit zero gates request
// - reserved bits read back as zero
`timescale 1ns/1ps
`include "wkev_params.svh"

module wkev_top (
  // clock and standby power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // wake sources
  input wire wkev_pkg::wkev_pins_type wake_pins,
  input wire logic watchdog_wake,
  // wake request and interrupt
  output logic wake_request_out_n,
  output logic irq
);

  // ==================================================================
  // state registers
  wkev_pkg::wkev_state_type state_q;
  wkev_pkg::wkev_state_type state_d;

  // ==================================================================
  // combinational helpers
  logic [`WKEV_PIN_COUNT-1:0] pins_active;
  logic [`WKEV_PIN_COUNT-1:0] pin_agree;
  logic [`WKEV_PIN_COUNT-1:0] pin_event;
  logic watchdog_event;
  logic [7:0] set_second;
  logic [7:0] set_third;
  logic [5:0] index;
  logic aligned;
  logic hit;
  logic setup_phase;
  logic write_access;
  logic [7:0] wdata;
  logic [7:0] read_mux;
  logic [7:0] clear_second;
  logic [7:0] clear_third;
  logic [7:0] irq_clear;
  logic [7:0] irq_set;
  logic request_now;
  logic [`WKEV_PIN_COUNT-1:0] level_next;
  logic primed;
  logic [7:0] request_terms;
  logic status_newly_set;

  // ==================================================================
  // apb decode
  assign index = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup_phase = psel & ~penable;
  assign wdata = pwdata[7:0];

  always_comb begin
    unique case (index)
      `WKEV_IDX_MASTER_EN,
      `WKEV_IDX_STS_SECOND,
      `WKEV_IDX_STS_THIRD,
      `WKEV_IDX_EN_FIRST,
      `WKEV_IDX_EN_SECOND,
      `WKEV_IDX_IRQ_STATUS,
      `WKEV_IDX_IRQ_MASK: begin
        hit = aligned;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // write lands only on the access edge; lane 0 carries the data
  assign write_access = psel & penable & pwrite & pstrb[0] & hit;

  // zero wait states: every access phase completes at once
  assign pready = 1'b1;

  // ==================================================================
  // read mux
  always_comb begin
    unique case (index)
      `WKEV_IDX_MASTER_EN: begin
        read_mux = {7'h00, state_q.wake_master_enable};
      end
      `WKEV_IDX_STS_SECOND: begin
        read_mux = state_q.wake_status_second & `WKEV_STS_SECOND_BITS;
      end
      `WKEV_IDX_STS_THIRD: begin
        read_mux = state_q.wake_status_third & `WKEV_STS_THIRD_BITS;
      end
      `WKEV_IDX_EN_FIRST: begin
        read_mux = state_q.wake_enable_first & `WKEV_EN_FIRST_BITS;
      end
      `WKEV_IDX_EN_SECOND: begin
        read_mux = state_q.wake_enable_second & `WKEV_EN_SECOND_BITS;
      end
      `WKEV_IDX_IRQ_STATUS: begin
        read_mux = state_q.irq_status & `WKEV_IRQ_BITS;
      end
      `WKEV_IDX_IRQ_MASK: begin
        read_mux = state_q.irq_mask & `WKEV_IRQ_BITS;
      end
      default: begin
        read_mux = 8'h00;
      end
    endcase
    if (!aligned) begin
      read_mux = 8'h00;
    end
  end

  // ==================================================================
  // pin conditioning
  // only the dedicated ring indicate pin is inverted to active high;
  // shared pins take any edge so either function is caught
  assign pins_active = wake_pins ^ {13'h0000, 1'b1};

  assign pin_agree = ~(state_q.sync_second ^ state_q.sync_third);

  // settled level moves only while the last two flops agree, so a pin
  // caught mid-change by the first flop is never counted twice
  assign level_next = (state_q.level & ~pin_agree)
    | (state_q.sync_third & pin_agree);

  // the flops fill from reset before any edge may count
  assign primed = (state_q.prime == `WKEV_PRIME_CYCLES);

  for (genvar p = 0; p < `WKEV_PIN_COUNT; p++) begin : g_pin
    localparam logic [`WKEV_PIN_COUNT-1:0] ANY_EDGE = `WKEV_ANY_EDGE_PINS;
    logic rise;
    logic fall;
    assign rise = level_next[p] & ~state_q.level[p];
    assign fall = state_q.level[p] & ~level_next[p];
    // shared pins count both edges; the dedicated ring pin only its
    // assertion, which is a rise once inverted
    if (ANY_EDGE[p]) begin : g_both
      assign pin_event[p] = primed & (rise | fall);
    end else begin : g_assert_only
      assign pin_event[p] = primed & rise;
    end
  end

  assign watchdog_event = watchdog_wake & ~state_q.watchdog_level;

  assign set_second = {watchdog_event, 1'b0, pin_event[5:0]}
    & `WKEV_STS_SECOND_BITS;

  assign set_third = pin_event[13:6] & `WKEV_STS_THIRD_BITS;

  // ==================================================================
  // write-one-to-clear strobes
  always_comb begin
    clear_second = 8'h00;
    clear_third = 8'h00;
    irq_clear = 8'h00;
    if (write_access) begin
      unique case (index)
        `WKEV_IDX_STS_SECOND: begin
          clear_second = wdata;
        end
        `WKEV_IDX_STS_THIRD: begin
          clear_third = wdata;
        end
        `WKEV_IDX_IRQ_STATUS: begin
          irq_clear = wdata;
        end
        default: begin
          clear_second = 8'h00;
        end
      endcase
    end
  end

  // ==================================================================
  // wake request
  // status enable master
  // master gates request
  // only the second status has an enable partner here, so the third
  // status and the first enable never reach the request
  assign request_terms = state_q.wake_status_second
    & state_q.wake_enable_second & `WKEV_STS_SECOND_BITS;
  assign request_now = state_q.wake_master_enable & (|request_terms);

  // some status bit goes from zero to one this cycle
  assign status_newly_set = |((set_second & ~state_q.wake_status_second)
    | (set_third & ~state_q.wake_status_third));

  // ==================================================================
  // next state
  always_comb begin
    state_d = state_q;

    state_d.sync_first = pins_active;
    state_d.sync_second = state_q.sync_first;
    state_d.sync_third = state_q.sync_second;
    state_d.level = level_next;
    if (!primed) begin
      state_d.prime = state_q.prime + 3'h1;
    end
    state_d.watchdog_level = watchdog_wake;

    state_d.wake_status_second =
      (state_q.wake_status_second & ~clear_second) | set_second;
    state_d.wake_status_third =
      (state_q.wake_status_third & ~clear_third) | set_third;

    if (write_access) begin
      unique case (index)
        `WKEV_IDX_MASTER_EN: begin
          state_d.wake_master_enable = wdata[0];
        end
        `WKEV_IDX_EN_FIRST: begin
          state_d.wake_enable_first = wdata & `WKEV_EN_FIRST_BITS;
        end
        `WKEV_IDX_EN_SECOND: begin
          state_d.wake_enable_second = wdata & `WKEV_EN_SECOND_BITS;
        end
        `WKEV_IDX_IRQ_MASK: begin
          state_d.irq_mask = wdata & `WKEV_IRQ_BITS;
        end
        default: begin
          state_d.irq_mask = state_q.irq_mask;
        end
      endcase
    end

    state_d.wake_request = request_now;

    // interrupt events: a status bit newly set, request rising
    irq_set = 8'h00;
    irq_set[`WKEV_IRQ_STATUS_SET] = status_newly_set;
    irq_set[`WKEV_IRQ_REQUEST_RISE] = request_now & ~state_q.wake_request;
    state_d.irq_status = ((state_q.irq_status & ~irq_clear) | irq_set)
      & `WKEV_IRQ_BITS;

    // read data and error captured in the setup cycle
    if (setup_phase) begin
      state_d.read_byte = read_mux;
      state_d.slave_error = ~hit;
    end
  end

  // ==================================================================
  // state register
  // status only standby reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ==================================================================
  // outputs
  assign prdata = {24'h000000, state_q.read_byte};
  assign pslverr = state_q.slave_error;
  assign wake_request_out_n = ~state_q.wake_request;
  // a set mask bit hides its status bit; all pass after reset
  assign irq = |(state_q.irq_status & ~state_q.irq_mask);

endmodule // wkev_top

// ===== test/wkev_chipset.sv
// wkev_chipset.sv: chipset end of the wake request line.
// assumes: request is active low and changes on pclk.
`timescale 1ns/1ps

module wkev_chipset (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // wake request
  input wire logic wake_request_out_n,
  output logic [7:0] wakes_q
);
  logic last_q;
  // ========
  // counts each new wake request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wakes_q <= 8'h00;
      last_q <= 1'b1;
    end else begin
      last_q <= wake_request_out_n;
      if (last_q && !wake_request_out_n) begin
        wakes_q <= wakes_q + 8'h01;
      end
    end
  end
endmodule // wkev_chipset

// ===== test/wkev_top_props.sv
// wkev_top_props.sv: port checks of the wake event block.
// assumes: bound into wkev_top; one clock domain.
`timescale 1ns/1ps

module wkev_top_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // wake
  input wire wkev_pkg::wkev_pins_type wake_pins,
  input wire logic watchdog_wake,
  input wire logic wake_request_out_n,
  input wire logic irq
);
  logic mst_q;
  logic [7:0] en2_q;
  logic wr;
  logic setup;
  assign wr = psel && penable && pwrite && pready && pstrb[0];
  assign setup = psel && !penable;
  // ========
  // shadows of master and second enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mst_q <= 1'b0;
      en2_q <= 8'h00;
    end else if (wr && paddr == 8'h04) begin
      mst_q <= pwdata[0];
    end else if (wr && paddr == 8'h18) begin
      en2_q <= pwdata[7:0] & 8'hbf;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_reset_quiet: assert property (
    $rose(presetn) |-> wake_request_out_n && !irq && prdata == 32'h0)
    else $error("outputs busy after reset");
  chk_master_gate: assert property (
    !mst_q && !$past(mst_q) |-> wake_request_out_n)
    else $error("request with master off");
  chk_enable_gate: assert property (
    en2_q == 8'h00 && $past(en2_q) == 8'h00 |-> wake_request_out_n)
    else $error("request with sources off");
  chk_wdog_wake: assert property (
    $rose(watchdog_wake) && en2_q[7] && mst_q
      |-> ##[1:4] !wake_request_out_n)
    else $error("watchdog raised no request");
  chk_upper_zero: assert property (
    prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_err_data: assert property (
    pslverr |-> prdata == 32'h0)
    else $error("error read not zero");
  chk_en2_read: assert property (
    setup && !pwrite && paddr == 8'h18
      |=> prdata[7:0] == $past(en2_q) && !pslverr)
    else $error("second enable read wrong");
  chk_sts2_rsvd: assert property (
    setup && !pwrite && paddr == 8'h0c |=> !prdata[6] && !pslverr)
    else $error("status reserved bit set");
endmodule // wkev_top_props

bind wkev_top wkev_top_props u_wkev_top_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .wake_pins(wake_pins),
  .watchdog_wake(watchdog_wake),
  .wake_request_out_n(wake_request_out_n), .irq(irq));

// ===== test/tb.sv
// tb.sv: register-level test of the wake event block.
// assumes: wkev_top apb slave; chipset model on the request line.
`timescale 1ns/1ps

module tb;
  localparam logic [7:0] MST = 8'h04, ST2 = 8'h0c, ST3 = 8'h10;
  localparam logic [7:0] EN1 = 8'h14, EN2 = 8'h18;
  localparam logic [7:0] IST = 8'h80, IMK = 8'h84;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic watchdog_wake, wake_request_out_n, irq;
  logic [7:0] paddr, wakes;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [13:0] hot;
  logic [7:0] regs [5] = '{MST, ST2, ST3, EN1, EN2};
  wkev_pkg::wkev_pins_type pins;
  int n_fail, n_checks;

  wkev_top u_wkev_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_pins(pins), .watchdog_wake(watchdog_wake),
    .wake_request_out_n(wake_request_out_n), .irq(irq));
  wkev_chipset u_wkev_chipset (.pclk(pclk), .presetn(presetn),
    .wake_request_out_n(wake_request_out_n), .wakes_q(wakes));

  // ========
  // tasks
  task automatic conclude();
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string s, input logic [31:0] v, e);
    n_checks++;
    if (v !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h seen %h", s, e, v);
    end
  endtask
  task automatic chk1(input string s, input logic v, e);
    check(s, {31'h0, v}, {31'h0, e});
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string s, input logic [7:0] a,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(s, rd, e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic flip(input logic [13:0] m);
    @(posedge pclk);
    pins <= wkev_pkg::wkev_pins_type'(pins ^ m);
    settle(6);
  endtask

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    conclude();
  end

  // ========
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, watchdog_wake} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    pins = wkev_pkg::wkev_pins_type'(14'h0001);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    settle(6);
    foreach (regs[i]) rdchk("reset", regs[i], 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk1("unmapped", err, 1'b1);
    apb(1'b0, 8'h0d, 32'h0);
    chk1("misaligned", err, 1'b1);
    apb(1'b1, EN1, 32'hff);
    rdchk("en1", EN1, 32'hce);
    apb(1'b1, EN2, 32'hff);
    rdchk("en2", EN2, 32'hbf);
    apb(1'b1, MST, 32'hff);
    rdchk("master", MST, 32'h1);
    apb(1'b1, EN2, 32'h0);
    apb(1'b1, IMK, 32'h3);
    for (int i = 0; i < 14; i++) begin
      hot = 14'h1 << i;
      flip(hot);
      rdchk("sts2", ST2, {26'h0, hot[5:0]});
      rdchk("sts3", ST3, {24'h0, hot[13:6]});
      apb(1'b1, ST2, 32'hff);
      apb(1'b1, ST3, 32'hff);
    end
    flip(14'h0041);
    rdchk("ri1 rise", ST2, 32'h0);
    rdchk("alt pin", ST3, 32'h1);
    apb(1'b1, ST3, 32'hff);
    chk1("no req", wake_request_out_n, 1'b1);
    chk1("irq masked", irq, 1'b0);
    rdchk("irq sts", IST, 32'h1);
    apb(1'b1, IMK, 32'h0);
    settle(1);
    chk1("irq up", irq, 1'b1);
    apb(1'b1, IST, 32'h1);
    settle(1);
    chk1("irq down", irq, 1'b0);
    apb(1'b1, EN2, 32'h80);
    @(posedge pclk);
    watchdog_wake <= 1'b1;
    settle(6);
    chk1("wdog req", wake_request_out_n, 1'b0);
    rdchk("wdog sts", ST2, 32'h80);
    apb(1'b1, ST2, 32'h80);
    settle(2);
    chk1("cleared", wake_request_out_n, 1'b1);
    apb(1'b1, EN2, 32'h2);
    flip(14'h0006);
    apb(1'b1, ST2, 32'h0);
    rdchk("w0", ST2, 32'h6);
    chk1("en req", wake_request_out_n, 1'b0);
    apb(1'b1, MST, 32'h0);
    settle(2);
    chk1("mst off", wake_request_out_n, 1'b1);
    apb(1'b1, MST, 32'h1);
    apb(1'b1, ST2, 32'h2);
    rdchk("w1c", ST2, 32'h4);
    settle(2);
    chk1("dis src", wake_request_out_n, 1'b1);
    check("chipset", {24'h0, wakes}, 32'h3);
    conclude();
  end
endmodule // tb
